/* logic/wwp_pump_ctrl.sv */
// wet well pump control: level sensors to start/stop and pilot relays
`timescale 1ns/1ps
module wwp_pump_ctrl
    import wwp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [wwp_pkg::WWP_IN_W-1:0] exp_in,
    output logic [wwp_pkg::WWP_RLY_W-1:0] exp_relay,
    output logic motor_start,
    output logic motor_stop,
    output logic sensor_fault
);
    import wwp_pkg::*;

    // level sensors and button picked off the card
    logic crit_in;
    logic high_in;
    logic low_in;
    logic btn_in;
    // sensor consistency results
    logic fault_now;
    logic well_empty;
    // button edge detector
    logic btn_q;
    logic btn_d;
    logic btn_press;
    // pumping state
    wwp_state_t state_q;
    wwp_state_t state_d;
    // commands into the starter logic
    logic start_q;
    logic start_d;
    logic stop_q;
    logic stop_d;
    // pilot relays
    logic [WWP_RLY_W-1:0] relay_q;
    logic [WWP_RLY_W-1:0] relay_d;
    // fault annunciation
    logic fault_q;
    logic fault_d;

    // pick sensors and button off the expansion inputs
    assign crit_in = exp_in[WWP_IN_CRIT];
    assign high_in = exp_in[WWP_IN_HIGH];
    assign low_in = exp_in[WWP_IN_LOW];
    assign btn_in = exp_in[WWP_IN_RESET];

    wwp_sensor_check u_check (
        .crit_high(crit_in),
        .high(high_in),
        .low(low_in),
        .fault(fault_now),
        .empty(well_empty)
    );

    // true for the latched fault state; several output groups decode it
    // decoding kept in one place so relay, stop and flag cannot disagree
    function automatic logic is_fault_state(input wwp_state_t s);
        is_fault_state = (s == WWP_FAULT);
    endfunction

    // button edge detector next values
    // a held button must clear only once, so only the rising edge counts
    always_comb
    begin
        btn_d = btn_in;
        btn_press = btn_in && !btn_q;
    end

    // button history; resets to the released level, so no false edge
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            btn_q <= WWP_BTN_RST;
        end
        else
        begin
            btn_q <= btn_d;
        end
    end

    // pumping state next value
    // pumping starts on high and ends when the well is empty or a sensor fault is seen
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            WWP_IDLE:
            begin
                // a fault wins over starting a new pumping cycle
                if (fault_now)
                    state_d = WWP_FAULT;
                else if (high_in)
                    state_d = WWP_PUMP;
            end
            WWP_PUMP:
            begin
                // low still wet keeps the cycle going after high drops
                if (fault_now)
                    state_d = WWP_FAULT;
                else if (well_empty)
                    state_d = WWP_IDLE;
            end
            WWP_FAULT:
            begin
                // fault stays latched while the condition persists
                if (btn_press && !fault_now)
                    state_d = high_in ? WWP_PUMP : WWP_IDLE;
            end
            default:
            begin
                // an unused code stops the motor rather than guess
                state_d = WWP_FAULT;
            end
        endcase
    end

    // state register; reset comes up idle with nothing commanded
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_q <= WWP_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // start and stop next values
    // commands feed starter logic directly, no pins needed
    // start follows the live high sensor, so a stuck latch cannot run dry
    always_comb
    begin
        start_d = (state_d == WWP_PUMP) && high_in;
        stop_d = is_fault_state(state_d)
            || well_empty;
    end

    // command registers; reset leaves both commands released
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            start_q <= WWP_CMD_RST;
            stop_q <= WWP_CMD_RST;
        end
        else
        begin
            start_q <= start_d;
            stop_q <= stop_d;
        end
    end

    // pilot relay next values; the spare relay stays released
    // critical lamp follows the raw input, even during a sensor fault
    always_comb
    begin
        relay_d = WWP_RLY_RST;
        relay_d[WWP_RLY_FAIL] = is_fault_state(state_d);
        relay_d[WWP_RLY_CRIT] = crit_in;
    end

    // relay registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            relay_q <= WWP_RLY_RST;
        end
        else
        begin
            relay_q <= relay_d;
        end
    end

    // fault annunciation next value
    // kept in its own flop so the output is registered like the rest
    always_comb
    begin
        fault_d = is_fault_state(state_d);
    end

    // fault annunciation register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            fault_q <= WWP_FAULT_RST;
        end
        else
        begin
            fault_q <= fault_d;
        end
    end

    // ports come straight from the registers
    assign motor_start = start_q;
    assign motor_stop = stop_q;
    assign exp_relay = relay_q;
    assign sensor_fault = fault_q;
endmodule

/* logic/wwp_pkg.sv */
// shared constants for the wet well pump controller
package wwp_pkg;
    // expansion input positions, zero based within the four-bit input group
    localparam int unsigned WWP_IN_RESET = 0;
    localparam int unsigned WWP_IN_CRIT = 1;
    localparam int unsigned WWP_IN_HIGH = 2;
    localparam int unsigned WWP_IN_LOW = 3;
    localparam int unsigned WWP_IN_W = 4;
    // expansion relay positions, zero based within the three-bit relay group
    localparam int unsigned WWP_RLY_FAIL = 0;
    localparam int unsigned WWP_RLY_CRIT = 1;
    localparam int unsigned WWP_RLY_SPARE = 2;
    localparam int unsigned WWP_RLY_W = 3;
    // reset values
    localparam logic WWP_FAULT_RST = 1'h0;
    localparam logic WWP_BTN_RST = 1'h0;
    localparam logic WWP_CMD_RST = 1'h0;
    localparam logic [WWP_RLY_W-1:0] WWP_RLY_RST = 3'h0;
    typedef enum logic [1:0] {
        WWP_IDLE,
        WWP_PUMP,
        WWP_FAULT
    } wwp_state_t;
endpackage

/* logic/wwp_sensor_check.sv */
// combinational consistency check of the three level sensors
`timescale 1ns/1ps
module wwp_sensor_check (
    input wire logic crit_high,
    input wire logic high,
    input wire logic low,
    output logic fault,
    output logic empty
);
    // low dry while an upper sensor is wet cannot happen physically
    always_comb
    begin
        fault = (!low && (high || crit_high))
            || (!high && crit_high);
        empty = !crit_high && !high && !low;
    end
endmodule

/* testbench/wwp_pump_ctrl_checker.sv */
// port assertions for the pump controller
`timescale 1ns/1ps
module wwp_pump_ctrl_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] exp_in,
    input wire logic [2:0] exp_relay,
    input wire logic motor_start,
    input wire logic motor_stop,
    input wire logic sensor_fault
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // inconsistent switch pattern, as seen at the pins
    wire logic bad = (!exp_in[3] && (exp_in[2] || exp_in[1])) || (!exp_in[2] && exp_in[1]);
    chk_fault_sets: assert property (bad |=> sensor_fault)
        else $error("fault missed");
    chk_fault_stops: assert property (
        sensor_fault |-> motor_stop && !motor_start && exp_relay[0])
        else $error("fault not shown");
    chk_crit_lamp: assert property (
        1'h1 |=> exp_relay[1] == $past(exp_in[1]))
        else $error("crit lamp");
    chk_dry_stop: assert property (
        exp_in[3:1] == 3'h0 |=> motor_stop)
        else $error("no stop");
    chk_high_start: assert property (
        exp_in[3:1] == 3'h6 && !sensor_fault |=> motor_start)
        else $error("no start");
    chk_start_cause: assert property (
        motor_start |-> $past(exp_in[2]))
        else $error("stray start");
    chk_clear_button: assert property (
        $fell(sensor_fault) |-> $past(exp_in[0]) && !$past(exp_in[0], 2))
        else $error("bad clear");
    chk_spare_off: assert property (
        exp_relay[2] == 1'h0)
        else $error("spare relay");
    chk_fault_holds: assert property (
        sensor_fault && !exp_in[0] |=> sensor_fault)
        else $error("fault dropped");
    chk_fault_cause: assert property (
        $rose(sensor_fault) |-> $past(bad))
        else $error("stray fault");
endmodule
bind wwp_pump_ctrl wwp_pump_ctrl_checker u_chk (.clk_sys(clk_sys), .rst(rst), .exp_in(exp_in),
    .exp_relay(exp_relay), .motor_start(motor_start), .motor_stop(motor_stop),
    .sensor_fault(sensor_fault));

/* testbench/wwp_well_model.sv */
// float switch model of the well, pilot lamps and the starter run latch
`timescale 1ns/1ps
module wwp_well_model #(
    parameter logic RLY1_FROM_LOGIC = 1'h1, // relay 1 sourced by internal logic
    parameter logic [15:0] HOST_MASK = 16'h4000, // host lets the logic command the motor
    parameter int MASK_LOGIC_BIT = 14
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] level,
    input wire logic [2:0] stuck,
    input wire logic [2:0] exp_relay,
    input wire logic motor_start,
    input wire logic motor_stop,
    output logic [2:0] sense,
    output logic lamp_fail,
    output logic lamp_crit,
    output logic motor_run
);
    // {low, high, crit} wet from the bottom up; card assumed in its port
    assign sense = {level >= 2'h1, level >= 2'h2, level == 2'h3} ^ stuck;
    // a relay left on another source would leave the failure lamp dark
    assign lamp_fail = RLY1_FROM_LOGIC && exp_relay[0];
    assign lamp_crit = exp_relay[1];
    // starter run latch; commands are ignored unless the host mask allows them
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            motor_run <= 1'h0;
        else if (HOST_MASK[MASK_LOGIC_BIT])
        begin
            if (motor_stop)
                motor_run <= 1'h0;
            else if (motor_start)
                motor_run <= 1'h1;
        end
    end
endmodule

/* testbench/tb_wwp_pump_ctrl.sv */
// self-checking bench for the pump controller
`timescale 1ns/1ps
module tb_wwp_pump_ctrl;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic btn = 1'b0;
    logic [1:0] level = 2'h0;
    logic [2:0] stuck = 3'h0;
    logic [2:0] sense;
    logic [2:0] exp_relay;
    logic motor_start;
    logic motor_stop;
    logic sensor_fault;
    logic lamp_fail;
    logic lamp_crit;
    logic motor_run;
    logic [5:0] n;
    logic run_exp = 1'b0;
    logic f_q = 1'b0;
    logic b_q = 1'b0;
    logic [5:0] q[$];
    int fails = 0;
    int samples_checked = 0;
    wwp_well_model u_well (.clk_sys(clk_sys), .rst(rst), .level(level), .stuck(stuck),
        .exp_relay(exp_relay), .motor_start(motor_start), .motor_stop(motor_stop),
        .sense(sense), .lamp_fail(lamp_fail), .lamp_crit(lamp_crit), .motor_run(motor_run));
    wwp_pump_ctrl dut (.clk_sys(clk_sys), .rst(rst), .exp_in({sense, btn}), .exp_relay(exp_relay),
        .motor_start(motor_start), .motor_stop(motor_stop), .sensor_fault(sensor_fault));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic check(input logic [5:0] seen, input logic [5:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            fails++;
            $display("unexpected at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // drive one cycle, then note the outputs due after that edge
    task automatic step(input logic [1:0] lv, input logic [2:0] sk, input logic b);
        logic c;
        #1;
        level = lv;
        stuck = sk;
        btn = b;
        @(posedge clk_sys);
        c = (!sense[2] && (sense[1] || sense[0])) || (!sense[1] && sense[0]);
        f_q = c || (f_q && !(b && !b_q)); // set wins over a clear
        b_q = b;
        q.push_back({f_q, 1'b0, sense[0], f_q, f_q || sense == 3'h0, sense[1] && !f_q});
    endtask
    // monitor: oldest note against the settled outputs
    initial forever
    begin
        @(posedge clk_sys);
        #2;
        if (q.size() > 0)
        begin
            n = q.pop_front();
            check({sensor_fault, exp_relay, motor_stop, motor_start}, n);
            check({4'h0, lamp_crit, lamp_fail}, {4'h0, n[3:2]});
            // the starter latches commands one edge after the block issues them
            check({5'h0, motor_run}, {5'h0, run_exp});
            run_exp = n[0] || (run_exp && !n[1]);
        end
    end
    initial
    begin
        void'($urandom(62374));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        step(2'h2, 3'h0, 1'b0);
        step(2'h3, 3'h2, 1'b1); // button while high switch stuck dry
        step(2'h0, 3'h0, 1'b1);
        repeat (400) step(2'($urandom), ($urandom % 4 == 0) ? 3'($urandom) : 3'h0,
            $urandom % 6 == 0);
        repeat (3) @(posedge clk_sys);
        final_report();
    end
    // hang guard, well past the planned run
    initial
    begin
        #30000;
        fails++;
        final_report();
    end
endmodule
